// *** rtl/cipher_engine.sv ***
// cipher engine control: buffer window decode, key pages and run sequencing
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// How it works
// - engine reached only through buffer window
// - fast access: writes in, old results out
// - separate initial key store never modified by a run
// - key and state pages chosen by mode
// - key reads give last round key
// - each run starts from stored initial key
// - mode zero selects code book operation
// - direction bit picks encrypt or decrypt
// - request bit starts a run
// - mirror location acts as control except that it cannot abort a run
// - mode, data, start in one burst
// - refuse access in sleep states
// - state_a or reset wipes everything
// - control access during run aborts it
// - engine runs independent of radio
// - code book both ways, chaining encrypt
// - chained mode xors previous result in
// - run takes the block operation time
// - old content shifts out one behind
module cipher_engine (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic trx_sleep,
	input wire logic state_a,
	input wire logic trx_reset,
	input wire logic acc_start,
	input wire logic acc_write,
	input wire logic [7:0] acc_addr,
	input wire logic byte_valid,
	input wire logic [7:0] byte_wdata,
	input wire logic acc_end,
	output logic [7:0] byte_rdata,
	output logic acc_refused,
	output logic busy,
	output logic done
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic clr, refused, ev, ev_wr, start_req, abort;
	logic is_stat, is_ctrl, is_mirror, is_data;
	logic [3:0] idx;
	logic [2:0] wmode;
	logic [7:0] rd_val;
	logic open_reg, open_next, wr_reg, wr_next;
	logic dir_reg, dir_next, dec_reg, dec_next, done_reg, done_next;
	logic [7:0] ptr_reg, ptr_next, rdata_reg, rdata_next;
	logic [2:0] mode_reg, mode_next;
	logic [9:0] cnt_reg, cnt_next;
	logic [127:0] st_reg, st_next, ik_reg, ik_next, rk_reg, rk_next;
	logic [127:0] prev_reg, prev_next, work_reg, work_next, wkey_reg, wkey_next;
	cipher_pkg::run_state_t fsm_reg, fsm_next;

	cipher_if cx ();

	cipher_round u_round (
		.rx(cx.rnd_mp)
	);

	cipher_key_step u_key (
		.kx(cx.key_mp)
	);

	assign cx.st_i = work_reg;
	assign cx.key_i = wkey_reg;
	assign cx.rnd = cnt_reg[3:0] + 4'h1;
	assign cx.dec = dec_reg;

	////////////////////////////////////////////////////////////////////////////
	// decode
	assign clr = srst | state_a | trx_reset;
	assign refused = trx_sleep | state_a | trx_reset;
	assign ev = byte_valid & open_reg & ~refused;
	assign ev_wr = ev & wr_reg;
	// only this window is owned here; other buffer addresses read as zero
	assign is_stat = ptr_reg == cipher_pkg::ADDR_STATUS;
	assign is_ctrl = ptr_reg == cipher_pkg::ADDR_CTRL;
	assign is_mirror = ptr_reg == cipher_pkg::ADDR_MIRROR;
	assign is_data = ptr_reg >= cipher_pkg::ADDR_DATA_LO && ptr_reg <= cipher_pkg::ADDR_DATA_HI;
	assign idx = 4'(ptr_reg - cipher_pkg::ADDR_DATA_LO);
	assign wmode = byte_wdata[cipher_pkg::CTRL_MODE_LSB +: 3];
	assign abort = ev & is_ctrl & (fsm_reg == cipher_pkg::RUN_BUSY);
	// a mirror write during a run cannot restart it; only 0x83 aborts first
	assign start_req = ev_wr & (is_ctrl | is_mirror) & byte_wdata[cipher_pkg::CTRL_REQ_BIT]
		& (wmode != cipher_pkg::MODE_KEY)
		& (fsm_reg == cipher_pkg::RUN_IDLE | abort);

	always_comb begin
		rd_val = 8'h00;
		if (is_stat) begin
			rd_val[cipher_pkg::STATUS_DONE_BIT] = done_reg;
		end else if (is_ctrl | is_mirror) begin
			rd_val[cipher_pkg::CTRL_MODE_LSB +: 3] = mode_reg;
			rd_val[cipher_pkg::CTRL_DIR_BIT] = dir_reg;
		end else if (is_data) begin
			if (mode_reg == cipher_pkg::MODE_KEY) begin
				rd_val = cipher_pkg::bsel(rk_reg, int'(idx));
			end else begin
				rd_val = cipher_pkg::bsel(st_reg, int'(idx));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		open_next = open_reg;
		wr_next = wr_reg;
		ptr_next = ptr_reg;
		rdata_next = rdata_reg;
		mode_next = mode_reg;
		dir_next = dir_reg;
		dec_next = dec_reg;
		done_next = done_reg;
		cnt_next = cnt_reg;
		fsm_next = fsm_reg;
		st_next = st_reg;
		ik_next = ik_reg;
		rk_next = rk_reg;
		prev_next = prev_reg;
		work_next = work_reg;
		wkey_next = wkey_reg;

		if (acc_start & ~refused) begin
			open_next = 1'h1;
			wr_next = acc_write;
			ptr_next = acc_addr;
		end else if (acc_end) begin
			open_next = 1'h0;
		end

		// no radio state steers the run, so it proceeds during frames and sleep
		unique case (fsm_reg)
			cipher_pkg::RUN_IDLE: begin
			end
			cipher_pkg::RUN_BUSY: begin
				cnt_next = cnt_reg + 10'h001;
				if (cnt_reg < 10'(cipher_pkg::ROUNDS)) begin
					work_next = cx.st_o;
					wkey_next = cx.key_o;
				end
				// rounds finish early; result is held back to the block time
				if (cnt_reg == cipher_pkg::AES_LAST) begin
					fsm_next = cipher_pkg::RUN_IDLE;
					done_next = 1'h1;
					st_next = work_reg;
					prev_next = work_reg;
					rk_next = wkey_reg;
				end
			end
		endcase

		if (byte_valid & refused) begin
			rdata_next = cipher_pkg::RDATA_RESET;
		end

		if (ev) begin
			rdata_next = rd_val;
			ptr_next = ptr_reg + 8'h01;
			if (wr_reg & (is_ctrl | is_mirror)) begin
				mode_next = wmode;
				dir_next = byte_wdata[cipher_pkg::CTRL_DIR_BIT];
			end
			if (wr_reg & is_data) begin
				if (mode_reg == cipher_pkg::MODE_KEY) begin
					ik_next[8 * (15 - int'(idx)) +: 8] = byte_wdata;
					rk_next[8 * (15 - int'(idx)) +: 8] = byte_wdata;
				end else begin
					st_next[8 * (15 - int'(idx)) +: 8] = byte_wdata;
				end
			end
		end

		if (abort) begin
			fsm_next = cipher_pkg::RUN_IDLE;
			cnt_next = 10'h000;
		end

		// earlier burst bytes are already in st_reg when the trigger arrives
		if (start_req) begin
			fsm_next = cipher_pkg::RUN_BUSY;
			cnt_next = 10'h000;
			done_next = 1'h0;
			dec_next = byte_wdata[cipher_pkg::CTRL_DIR_BIT];
			// chaining only in the encrypt direction
			if (wmode == cipher_pkg::MODE_CBC && !byte_wdata[cipher_pkg::CTRL_DIR_BIT]) begin
				work_next = st_reg ^ prev_reg ^ ik_reg;
			end else begin
				work_next = st_reg ^ ik_reg;
			end
			wkey_next = ik_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk_sys) begin
		if (clr) begin
			open_reg <= 1'h0;
			wr_reg <= 1'h0;
			ptr_reg <= 8'h00;
			rdata_reg <= cipher_pkg::RDATA_RESET;
			mode_reg <= cipher_pkg::MODE_RESET;
			dir_reg <= cipher_pkg::DIR_RESET;
			dec_reg <= cipher_pkg::DIR_RESET;
			done_reg <= 1'h0;
			cnt_reg <= 10'h000;
			fsm_reg <= cipher_pkg::RUN_IDLE;
			st_reg <= cipher_pkg::BLOCK_RESET;
			ik_reg <= cipher_pkg::BLOCK_RESET;
			rk_reg <= cipher_pkg::BLOCK_RESET;
			prev_reg <= cipher_pkg::BLOCK_RESET;
			work_reg <= cipher_pkg::BLOCK_RESET;
			wkey_reg <= cipher_pkg::BLOCK_RESET;
		end else begin
			open_reg <= open_next;
			wr_reg <= wr_next;
			ptr_reg <= ptr_next;
			rdata_reg <= rdata_next;
			mode_reg <= mode_next;
			dir_reg <= dir_next;
			dec_reg <= dec_next;
			done_reg <= done_next;
			cnt_reg <= cnt_next;
			fsm_reg <= fsm_next;
			st_reg <= st_next;
			ik_reg <= ik_next;
			rk_reg <= rk_next;
			prev_reg <= prev_next;
			work_reg <= work_next;
			wkey_reg <= wkey_next;
		end
	end

	assign byte_rdata = rdata_reg;
	assign acc_refused = refused & (byte_valid | acc_start);
	assign busy = fsm_reg == cipher_pkg::RUN_BUSY;
	assign done = done_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks
	run_time_a: assert property (@(posedge clk_sys) disable iff (clr)
		$rose(done_reg) |-> $past(cnt_reg) == cipher_pkg::AES_LAST)
		else $error("done rose before the block time elapsed");

	abort_run_a: assert property (@(posedge clk_sys) disable iff (clr)
		(abort && !start_req) |=> fsm_reg == cipher_pkg::RUN_IDLE && !done_reg)
		else $error("control access did not abort the run");

	key_page_a: assert property (@(posedge clk_sys) disable iff (clr)
		(ev_wr && is_data && mode_reg == cipher_pkg::MODE_KEY && fsm_reg == cipher_pkg::RUN_IDLE)
		|=> $stable(st_reg) && cipher_pkg::bsel(ik_reg, int'($past(idx))) == $past(byte_wdata))
		else $error("key write leaked into the state page");

	init_key_a: assert property (@(posedge clk_sys) disable iff (clr)
		!(ev_wr && is_data && mode_reg == cipher_pkg::MODE_KEY) |=> $stable(ik_reg))
		else $error("initial key changed without a key write");

	mirror_start_a: assert property (@(posedge clk_sys) disable iff (clr)
		(ev_wr && is_mirror && byte_wdata[cipher_pkg::CTRL_REQ_BIT]
		&& wmode == cipher_pkg::MODE_ECB && fsm_reg == cipher_pkg::RUN_IDLE)
		|=> busy && cnt_reg == 10'h000 && wkey_reg == $past(ik_reg)
		&& work_reg == $past(st_reg ^ ik_reg))
		else $error("mirror request did not start from stored key and data");

	sleep_refuse_a: assert property (@(posedge clk_sys) disable iff (clr)
		(byte_valid && trx_sleep && fsm_reg == cipher_pkg::RUN_IDLE)
		|=> $stable(st_reg) && $stable(mode_reg)
		&& byte_rdata == 8'h00)
		else $error("access taken while asleep");

	wipe_a: assert property (@(posedge clk_sys) disable iff (srst)
		(state_a || trx_reset) |=> ik_reg == 128'h0 && st_reg == 128'h0 && rk_reg == 128'h0
		&& mode_reg == cipher_pkg::MODE_RESET && !busy)
		else $error("state_a or reset left engine contents");

	fast_read_a: assert property (@(posedge clk_sys) disable iff (clr)
		(ev && is_data && mode_reg != cipher_pkg::MODE_KEY)
		|=> byte_rdata == cipher_pkg::bsel($past(st_reg), int'($past(idx))))
		else $error("old state byte not returned one byte behind");

	key_read_a: assert property (@(posedge clk_sys) disable iff (clr)
		(ev && is_data && mode_reg == cipher_pkg::MODE_KEY)
		|=> byte_rdata == cipher_pkg::bsel($past(rk_reg), int'($past(idx))))
		else $error("key read did not return the round key");

	mode_sel_a: assert property (@(posedge clk_sys) disable iff (clr)
		(ev_wr && is_ctrl && wmode == cipher_pkg::MODE_ECB)
		|=> mode_reg == cipher_pkg::MODE_ECB
		&& dir_reg == $past(byte_wdata[cipher_pkg::CTRL_DIR_BIT]))
		else $error("control write did not set mode and direction");

	cbc_chain_a: assert property (@(posedge clk_sys) disable iff (clr)
		(start_req && wmode == cipher_pkg::MODE_CBC && !byte_wdata[cipher_pkg::CTRL_DIR_BIT])
		|=> work_reg == $past(st_reg ^ prev_reg ^ ik_reg))
		else $error("chained run did not fold in previous result");

	run_on_a: assert property (@(posedge clk_sys) disable iff (clr)
		(busy && trx_sleep && cnt_reg != cipher_pkg::AES_LAST)
		|=> busy && cnt_reg == $past(cnt_reg) + 10'h001)
		else $error("run stalled by transceiver state");

endmodule
`default_nettype wire

// *** inc/cipher_pkg.sv ***
// constants, types and gf(2^8) helpers for the cipher engine
package cipher_pkg;

	// buffer window locations
	localparam logic [7:0] ADDR_STATUS = 8'h82;
	localparam logic [7:0] ADDR_CTRL = 8'h83;
	localparam logic [7:0] ADDR_DATA_LO = 8'h84;
	localparam logic [7:0] ADDR_DATA_HI = 8'h93;
	localparam logic [7:0] ADDR_MIRROR = 8'h94;

	// control and status byte fields
	localparam int CTRL_REQ_BIT = 7;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_DIR_BIT = 3;
	localparam int STATUS_DONE_BIT = 0;

	// engine modes and reset values
	localparam logic [2:0] MODE_ECB = 3'h0;
	localparam logic [2:0] MODE_KEY = 3'h1;
	localparam logic [2:0] MODE_CBC = 3'h2;
	localparam logic [2:0] MODE_RESET = MODE_ECB;
	localparam logic DIR_RESET = 1'h0;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [127:0] BLOCK_RESET = 128'h0;

	// run timing
	localparam real CLK_MHZ = 40.0;
	localparam real T_AES_US = 23.4;
	localparam int AES_CYCLES = int'($ceil(T_AES_US * CLK_MHZ - 1.0e-6));
	localparam logic [9:0] AES_LAST = 10'(AES_CYCLES - 1);
	localparam logic [3:0] ROUNDS = 4'hA;

	typedef enum logic {RUN_IDLE, RUN_BUSY} run_state_t;

	function automatic logic [7:0] xt(input logic [7:0] a);
		return {a[6:0], 1'h0} ^ (a[7] ? 8'h1B : 8'h00);
	endfunction

	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ x;
			x = xt(x);
		end
		return p;
	endfunction

	// a^254 is the field inverse, and maps zero to zero as the s-box wants
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] p;
		logic [7:0] r;
		p = a;
		r = 8'h01;
		for (int i = 1; i < 8; i++) begin
			p = gmul(p, p);
			r = gmul(r, p);
		end
		return r;
	endfunction

	function automatic logic [7:0] rl(input logic [7:0] a, input int n);
		return 8'((a << n) | (a >> (8 - n)));
	endfunction

	function automatic logic [7:0] sbox(input logic [7:0] a);
		logic [7:0] b;
		b = ginv(a);
		return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
	endfunction

	function automatic logic [7:0] isbox(input logic [7:0] a);
		return ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
	endfunction

	function automatic logic [7:0] rcon(input logic [3:0] r);
		logic [7:0] c;
		c = 8'h01;
		for (int i = 1; i < 10; i++) begin
			if (i < r) c = xt(c);
		end
		return c;
	endfunction

	// byte 0 is the first byte of the block on the serial port
	function automatic logic [7:0] bsel(input logic [127:0] v, input int i);
		return v[8 * (15 - i) +: 8];
	endfunction

endpackage

// *** inc/cipher_if.sv ***
// round and key-schedule hookup between control and datapath
`timescale 1ns/1ps
`default_nettype none
interface cipher_if;
	logic [127:0] st_i;
	logic [127:0] key_i;
	logic [127:0] st_o;
	logic [127:0] key_o;
	logic [3:0] rnd;
	logic dec;
	modport ctl (output st_i, key_i, rnd, dec, input st_o, key_o);
	modport rnd_mp (input st_i, key_o, rnd, dec, output st_o);
	modport key_mp (input key_i, rnd, dec, output key_o);
endinterface
`default_nettype wire

// *** rtl/cipher_key_step.sv ***
// one key-schedule step, forward for encryption, backward for decryption
`timescale 1ns/1ps
`default_nettype none
module cipher_key_step (
	cipher_if.key_mp kx
);
	logic [7:0] rc;
	logic [31:0] w0, w1, w2, w3, n0, n1, n2, n3, t;

	function automatic logic [31:0] gw(input logic [31:0] w, input logic [7:0] c);
		return {cipher_pkg::sbox(w[23:16]) ^ c, cipher_pkg::sbox(w[15:8]),
			cipher_pkg::sbox(w[7:0]), cipher_pkg::sbox(w[31:24])};
	endfunction

	always_comb begin
		rc = cipher_pkg::rcon(kx.dec ? 4'(5'd11 - {1'h0, kx.rnd}) : kx.rnd);
		{w0, w1, w2, w3} = kx.key_i;
		if (!kx.dec) begin
			t = gw(w3, rc);
			n0 = w0 ^ t;
			n1 = w1 ^ n0;
			n2 = w2 ^ n1;
			n3 = w3 ^ n2;
		end else begin
			// walking back from the last round key toward the initial one
			n3 = w3 ^ w2;
			n2 = w2 ^ w1;
			n1 = w1 ^ w0;
			t = gw(n3, rc);
			n0 = w0 ^ t;
		end
		kx.key_o = {n0, n1, n2, n3};
	end
endmodule
`default_nettype wire

// *** rtl/cipher_round.sv ***
// one cipher round, both directions, final round without column mixing
`timescale 1ns/1ps
`default_nettype none
module cipher_round (
	cipher_if.rnd_mp rx
);
	logic last;
	logic [31:0] col_o [4];

	assign last = rx.rnd == cipher_pkg::ROUNDS;

	for (genvar c = 0; c < 4; c++) begin : g_col
		logic [7:0] e [4];
		logic [7:0] d [4];
		logic [31:0] me, im, ed, dd;
		for (genvar r = 0; r < 4; r++) begin : g_row
			assign e[r] = cipher_pkg::sbox(cipher_pkg::bsel(rx.st_i, r + 4 * ((c + r) % 4)));
			assign d[r] = cipher_pkg::isbox(cipher_pkg::bsel(rx.st_i, r + 4 * ((c - r + 4) % 4)))
				^ cipher_pkg::bsel(rx.key_o, r + 4 * c);
		end
		assign me = {cipher_pkg::xt(e[0]) ^ cipher_pkg::xt(e[1]) ^ e[1] ^ e[2] ^ e[3],
			e[0] ^ cipher_pkg::xt(e[1]) ^ cipher_pkg::xt(e[2]) ^ e[2] ^ e[3],
			e[0] ^ e[1] ^ cipher_pkg::xt(e[2]) ^ cipher_pkg::xt(e[3]) ^ e[3],
			cipher_pkg::xt(e[0]) ^ e[0] ^ e[1] ^ e[2] ^ cipher_pkg::xt(e[3])};
		assign im = {cipher_pkg::gmul(d[0], 8'h0E) ^ cipher_pkg::gmul(d[1], 8'h0B)
				^ cipher_pkg::gmul(d[2], 8'h0D) ^ cipher_pkg::gmul(d[3], 8'h09),
			cipher_pkg::gmul(d[0], 8'h09) ^ cipher_pkg::gmul(d[1], 8'h0E)
				^ cipher_pkg::gmul(d[2], 8'h0B) ^ cipher_pkg::gmul(d[3], 8'h0D),
			cipher_pkg::gmul(d[0], 8'h0D) ^ cipher_pkg::gmul(d[1], 8'h09)
				^ cipher_pkg::gmul(d[2], 8'h0E) ^ cipher_pkg::gmul(d[3], 8'h0B),
			cipher_pkg::gmul(d[0], 8'h0B) ^ cipher_pkg::gmul(d[1], 8'h0D)
				^ cipher_pkg::gmul(d[2], 8'h09) ^ cipher_pkg::gmul(d[3], 8'h0E)};
		assign ed = (last ? {e[0], e[1], e[2], e[3]} : me) ^ rx.key_o[8 * (15 - 4 * c) - 24 +: 32];
		assign dd = last ? {d[0], d[1], d[2], d[3]} : im;
		assign col_o[c] = rx.dec ? dd : ed;
	end

	assign rx.st_o = {col_o[0], col_o[1], col_o[2], col_o[3]};
endmodule
`default_nettype wire

// *** sim/host_model.sv ***
// behavioural host on the far side of the buffer window
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_sys,
	output logic acc_start,
	output logic acc_write,
	output logic [7:0] acc_addr,
	output logic byte_valid,
	output logic [7:0] byte_wdata,
	output logic acc_end,
	input wire logic [7:0] byte_rdata
);
	logic [7:0] wbuf [0:19];
	logic [7:0] rbuf [0:19];
	int gap;

	initial begin
		acc_start = 1'b0;
		acc_write = 1'b0;
		acc_addr = 8'h00;
		byte_valid = 1'b0;
		byte_wdata = 8'h00;
		acc_end = 1'b0;
		gap = 0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// one access: open, n bytes from wbuf, close; old contents land in rbuf
	task automatic xfer(input logic wr, input logic [7:0] addr, input int n);
		@(posedge clk_sys);
		#2;
		acc_start = 1'b1;
		acc_write = wr;
		acc_addr = addr;
		@(posedge clk_sys);
		#2;
		// released lines toggle so a stale value is never mistaken for a held one
		acc_start = 1'b0;
		acc_addr = ~addr;
		for (int i = 0; i < n; i++) begin
			byte_valid = 1'b1;
			byte_wdata = wbuf[i];
			@(posedge clk_sys);
			#2;
			rbuf[i] = byte_rdata;
			// a slow host leaves idle cycles between bytes
			if (gap > 0) begin
				byte_valid = 1'b0;
				byte_wdata = ~byte_wdata;
				repeat (gap) @(posedge clk_sys);
				#2;
			end
		end
		byte_valid = 1'b0;
		byte_wdata = ~byte_wdata;
		acc_end = 1'b1;
		@(posedge clk_sys);
		#2;
		acc_end = 1'b0;
		acc_write = ~wr;
	endtask
endmodule
`default_nettype wire

// *** sim/aes128_security_module_ctrl_test.sv ***
// self-checking bench for the cipher engine behind the buffer window
`timescale 1ns/1ps
`default_nettype none
module aes128_security_module_ctrl_test;
	// standard known-answer vectors, so no cipher model is needed here
	localparam logic [127:0] KEY = 128'h000102030405060708090A0B0C0D0E0F;
	localparam logic [127:0] PT = 128'h00112233445566778899AABBCCDDEEFF;
	localparam logic [127:0] CT = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
	localparam logic [127:0] LRK = 128'h13111D7FE3944A17F307A78B4D2B30C5;
	localparam logic [127:0] ZCT = 128'h66E94BD4EF8A2C3B884CFA59CA342B2E;
	logic clk_sys, srst, trx_sleep, state_a, trx_reset;
	wire acc_start, acc_write, byte_valid, acc_end, acc_refused, busy, done;
	wire [7:0] acc_addr, byte_wdata, byte_rdata;
	int fail_count, samples_checked, run_len, ref_cnt, run_base, ref_base;

	host_model host (.clk_sys(clk_sys), .acc_start(acc_start), .acc_write(acc_write),
		.acc_addr(acc_addr), .byte_valid(byte_valid), .byte_wdata(byte_wdata),
		.acc_end(acc_end), .byte_rdata(byte_rdata));
	cipher_engine DUT (.clk_sys(clk_sys), .srst(srst), .trx_sleep(trx_sleep),
		.state_a(state_a), .trx_reset(trx_reset), .acc_start(acc_start),
		.acc_write(acc_write), .acc_addr(acc_addr), .byte_valid(byte_valid),
		.byte_wdata(byte_wdata), .acc_end(acc_end), .byte_rdata(byte_rdata),
		.acc_refused(acc_refused), .busy(busy), .done(done));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	initial begin
		run_len = 0;
		ref_cnt = 0;
	end

	// free-running tallies; scenarios take differences against a saved base
	always @(posedge clk_sys) begin
		if (busy === 1'b1) run_len <= run_len + 1;
		if (acc_refused === 1'b1) ref_cnt <= ref_cnt + 1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		$display("checks=%0d failures=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [127:0] rblk(input int off);
		for (int i = 0; i < 16; i++) rblk[8 * (15 - i) +: 8] = host.rbuf[off + i];
	endfunction

	// control byte, block, then mirror byte only when it carries a request
	task automatic burst(input logic [7:0] ctl, input logic [127:0] blk, input logic [7:0] mir);
		host.wbuf[0] = ctl;
		for (int i = 0; i < 16; i++) host.wbuf[i + 1] = blk[8 * (15 - i) +: 8];
		host.wbuf[17] = mir;
		run_base = run_len;
		host.xfer(1'b1, cipher_pkg::ADDR_CTRL, mir[7] ? 18 : 17);
	endtask

	task automatic setctl(input logic [7:0] v);
		host.wbuf[0] = v;
		host.xfer(1'b1, cipher_pkg::ADDR_CTRL, 1);
	endtask

	task automatic rdblk;
		host.xfer(1'b0, cipher_pkg::ADDR_DATA_LO, 16);
	endtask

	task automatic wait_run;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 1200) begin
			@(posedge clk_sys);
			n++;
		end
		#2;
		if (n >= 1200) begin
			chk(n, 0);
			final_report;
		end else begin
			chk(run_len - run_base, cipher_pkg::AES_CYCLES);
			chk(busy, 1'b0);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_vals;
		host.xfer(1'b0, cipher_pkg::ADDR_STATUS, 19);
		chk({host.rbuf[0], host.rbuf[1], host.rbuf[18]}, 24'h000000);
		chk(rblk(2), cipher_pkg::BLOCK_RESET);
		chk({busy, done}, 2'h0);
		$display("test reset_vals done");
	endtask

	task automatic t_key_page;
		burst(8'h10, KEY, 8'h00);
		host.xfer(1'b0, cipher_pkg::ADDR_CTRL, 17);
		chk(host.rbuf[0], 8'h10);
		chk(rblk(1), KEY);
		setctl(8'h00);
		rdblk;
		chk(rblk(0), cipher_pkg::BLOCK_RESET);
		$display("test key_page done");
	endtask

	task automatic t_ecb_enc;
		burst(8'h00, PT, 8'h80);
		chk({busy, done}, 2'h2);
		wait_run;
		// the burst that starts the second run reads out the first result
		burst(8'h00, PT, 8'h80);
		chk(rblk(1), CT);
		wait_run;
		rdblk;
		chk(rblk(0), CT);
		setctl(8'h10);
		rdblk;
		chk(rblk(0), LRK);
		$display("test ecb_enc done");
	endtask

	task automatic t_ecb_dec;
		burst(8'h10, LRK, 8'h00);
		host.gap = 2;
		burst(8'h08, CT, 8'h88);
		host.gap = 0;
		wait_run;
		rdblk;
		chk(rblk(0), PT);
		$display("test ecb_dec done");
	endtask

	task automatic t_cbc;
		burst(8'h10, KEY, 8'h00);
		burst(8'h00, PT, 8'h80);
		wait_run;
		// chaining folds the last result back in, so the core sees PT again
		burst(8'h20, PT ^ CT, 8'hA0);
		wait_run;
		rdblk;
		chk(rblk(0), CT);
		$display("test cbc done");
	endtask

	task automatic t_refuse;
		// a chained run keeps going while the transceiver sleeps
		burst(8'h20, PT ^ CT, 8'hA0);
		trx_sleep = 1'b1;
		ref_base = ref_cnt;
		host.xfer(1'b0, cipher_pkg::ADDR_DATA_LO, 1);
		trx_sleep = 1'b0;
		chk(host.rbuf[0], 8'h00);
		chk(ref_cnt - ref_base, 2);
		wait_run;
		rdblk;
		chk(rblk(0), CT);
		$display("test refuse done");
	endtask

	task automatic t_abort;
		setctl(8'h80);
		chk(busy, 1'b1);
		repeat (5) @(posedge clk_sys);
		#2;
		host.xfer(1'b0, cipher_pkg::ADDR_CTRL, 1);
		chk({busy, done}, 2'h0);
		chk(host.rbuf[0], 8'h00);
		$display("test abort done");
	endtask

	task automatic t_wipe;
		setctl(8'h18);
		state_a = 1'b1;
		ref_base = ref_cnt;
		host.xfer(1'b0, cipher_pkg::ADDR_CTRL, 1);
		state_a = 1'b0;
		chk(ref_cnt - ref_base, 2);
		host.xfer(1'b0, cipher_pkg::ADDR_CTRL, 17);
		chk(host.rbuf[0], 8'h00);
		chk(rblk(1), cipher_pkg::BLOCK_RESET);
		// a wiped key is all zero, which has its own known answer
		burst(8'h00, 128'h0, 8'h80);
		wait_run;
		rdblk;
		chk(rblk(0), ZCT);
		trx_reset = 1'b1;
		@(posedge clk_sys);
		#2;
		trx_reset = 1'b0;
		chk(done, 1'b0);
		$display("test wipe done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		fail_count = 0;
		samples_checked = 0;
		run_base = 0;
		ref_base = 0;
		srst = 1'b1;
		trx_sleep = 1'b0;
		state_a = 1'b0;
		trx_reset = 1'b0;
		repeat (6) @(posedge clk_sys);
		#2;
		srst = 1'b0;
		t_reset_vals;
		t_key_page;
		t_ecb_enc;
		t_ecb_dec;
		t_cbc;
		t_refuse;
		t_abort;
		t_wipe;
		final_report;
	end
endmodule
`default_nettype wire
